// ===== ric_map.vh
// Register map, field positions and reset values of the reset and
// interrupt control block. Definitions only; included by bare name.
`ifndef RIC_MAP_VH
`define RIC_MAP_VH
// Register indices; byte address is four times the index
`define RIC_A_LVSC   16'h1809
`define RIC_A_IRQSC  16'h180b
`define RIC_A_RSTC   16'h180c
`define RIC_A_PASC   16'h1844
`define RIC_A_PAPS   16'h1845
`define RIC_A_PAES   16'h1846
`define RIC_A_PBSC   16'h184c
`define RIC_A_PBPS   16'h184d
`define RIC_A_PBES   16'h184e
`define RIC_A_PDSC   16'h1854
`define RIC_A_PDPS   16'h1855
`define RIC_A_PDES   16'h1856
`define RIC_A_EVST   16'h1830
`define RIC_A_EVCLR  16'h1831
`define RIC_A_EVEN   16'h1832
// Low-voltage status/control fields
`define RIC_LV_WF    7
`define RIC_LV_WACK  6
`define RIC_LV_WIE   5
`define RIC_LV_RE    4
// IRQ pin status/control fields
`define RIC_IRQ_PDD  6
`define RIC_IRQ_POL  5
`define RIC_IRQ_PE   4
`define RIC_IRQ_F    3
`define RIC_IRQ_ACK  2
`define RIC_IRQ_IE   1
`define RIC_IRQ_MOD  0
// Port status/control fields
`define RIC_P_IF     3
`define RIC_P_ACK    2
`define RIC_P_IE     1
`define RIC_P_MOD    0
// Event status bits
`define RIC_EV_IRQ   0
`define RIC_EV_PORT  1
`define RIC_EV_LVW   2
`define RIC_EV_TAKE  3
`define RIC_EV_W     4
// Vector table
`define RIC_VEC_RST  16'hfffe
`define RIC_VEC_BASE 16'hffc0
`define RIC_V_SWI    1
`define RIC_V_IRQ    2
`define RIC_V_LVW    3
`define RIC_V_PORT   22
`define RIC_V_RSVD   32'h3c38_0000
// Reset stack pointer, hidden reset-cause bits and stack frame byte count
`define RIC_SP_INIT  16'h00ff
`define RIC_RST_HIDE 8'h01
`define RIC_PUSH_N   3'h5
`endif

// ===== ric_mem_model.sv
// Program memory beside the block: a byte one cycle after mem_rd.
// Assumes the block's clock; contents are a hash of the address.
`timescale 1ns/10ps
`default_nettype none
module ric_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output var  logic [7:0]  mem_rdata
);
  initial mem_rdata = 8'h00;
  // Idle bus toggles so a stale byte never passes for data
  always @(posedge clk) begin
    if (mem_rd)
      mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'ha5;
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule // ric_mem_model
`default_nettype wire

// ===== ric_props.sv
// Port-level checks for ric_top: boot fetch, stacking, reset state.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "ric_map.vh"
module ric_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] avs_address,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic        stk_we,
  input wire logic [15:0] stk_addr,
  input wire logic [15:0] sp_value,
  input wire logic        sp_load,
  input wire logic        i_mask,
  input wire logic        reset_active,
  input wire logic        irq_pull_up,
  input wire logic        irq_pull_down,
  input wire logic        pc_load,
  input wire logic        int_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  sequence s_fetch;
    mem_rd ##1 (mem_rd && mem_addr == $past(mem_addr) + 16'h1) ##1 !mem_rd;
  endsequence
  sequence s_push;
    stk_we [*5] ##1 (!stk_we && i_mask && sp_load
      && sp_value == $past(stk_addr) - 16'h1);
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_boot_addr: assert property ($rose(mem_rd) && reset_active
    |-> mem_addr == `RIC_VEC_RST) else $error("boot fetch not at fffe");
  a_vec_pair: assert property ($rose(mem_rd) |-> s_fetch ##1 pc_load)
    else $error("vector fetch not high then low byte");
  a_reset_core: assert property ($rose(nrst) |->
    sp_value == `RIC_SP_INIT && sp_load && i_mask)
    else $error("reset core state wrong");
  a_reset_pins: assert property ($rose(nrst) |-> reset_active
    && !irq_pull_up && !irq_pull_down && !int_out && !mem_rd)
    else $error("reset pin state wrong");
  a_push_stack: assert property ($rose(stk_we) |-> s_push)
    else $error("stack frame not five bytes");
  a_stack_down: assert property (stk_we && $past(stk_we) |->
    stk_addr == $past(stk_addr) - 16'h1) else $error("stack not down");
  a_take_to_pc: assert property ($rose(stk_we) |-> ##8 pc_load)
    else $error("vector load late");
  a_mask_swi: assert property ($rose(stk_we) && $past(i_mask) |->
    ##5 (mem_rd && mem_addr == 16'hfffc))
    else $error("masked entry not software interrupt");
  a_pull_excl: assert property (!(irq_pull_up && irq_pull_down))
    else $error("both pulls on");
  a_ack_reads0: assert property (avs_read && !avs_waitrequest
    && (avs_address == `RIC_A_IRQSC || avs_address == `RIC_A_PASC
    || avs_address == `RIC_A_PBSC || avs_address == `RIC_A_PDSC)
    |-> !avs_readdata[2]) else $error("ack bit reads one");
  a_cause_nodbg: assert property (avs_read && !avs_waitrequest
    && avs_address == `RIC_A_RSTC |-> !avs_readdata[0])
    else $error("debug reset recorded");
endmodule // ric_props
`default_nettype wire

// ===== ric_top.v
// Reset and interrupt control: reset vector fetch, stack frame push,
// IRQ pin and port pin detection, prioritised vector selection.
// Assumes a same-clock byte memory answering one cycle after mem_rd,
// a core that stacks through stk_* and an Avalon-MM master.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "ric_map.vh"

////////////////////////////////////////////////////////////////////////
// One port's pin detector; pins are synchronised here
module ric_port #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] pins,
  input  wire [W-1:0] pin_sel,
  input  wire [W-1:0] edge_sel,
  input  wire         mode,
  input  wire         ack,
  output reg          flag
);
  reg  [W-1:0] s1;
  reg  [W-1:0] s2;
  reg  [W-1:0] prev;
  wire [W-1:0] asserted = pin_sel & ~(s2 ^ edge_sel);
  wire         edge_hit = |(asserted & ~prev);
  wire         level    = |asserted;

  always @(posedge clk) begin
    if (!nrst) begin
      s1   <= {W{1'b0}};
      s2   <= {W{1'b0}};
      prev <= {W{1'b0}};
      flag <= 1'b0;
    end else begin
      s1   <= pins;
      s2   <= s1;
      prev <= asserted;
      // New detection beats a same-cycle acknowledge
      flag <= edge_hit | (mode & level) | (flag & ~ack);
    end
  end
endmodule // ric_port

////////////////////////////////////////////////////////////////////////
module ric_top (
  input  wire        clk,
  input  wire        nrst,
  input  wire [15:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        irq_pin,
  input  wire [7:0]  port_a_pins,
  input  wire [7:0]  port_b_pins,
  input  wire [7:0]  port_d_pins,
  input  wire        lv_warning,
  input  wire [7:0]  rst_cause,
  input  wire [31:0] ext_req,
  input  wire        core_boundary,
  input  wire        core_sei,
  input  wire        core_cli,
  input  wire [15:0] core_pc,
  input  wire [7:0]  core_x,
  input  wire [7:0]  core_a,
  input  wire [7:0]  core_ccr,
  input  wire [15:0] core_sp,
  input  wire [7:0]  mem_rdata,
  output reg         mem_rd,
  output reg  [15:0] mem_addr,
  output reg         stk_we,
  output reg  [15:0] stk_addr,
  output reg  [7:0]  stk_data,
  output reg  [15:0] pc_value,
  output reg         pc_load,
  output reg  [15:0] sp_value,
  output reg         sp_load,
  output reg         i_mask,
  output reg         reset_active,
  output reg         irq_pull_up,
  output reg         irq_pull_down,
  output reg         irq_pin_level,
  output reg         lv_reset_en,
  output reg         int_out
);
  localparam S_BOOT = 6'h01;
  localparam S_IDLE = 6'h02;
  localparam S_PUSH = 6'h04;
  localparam S_FHI  = 6'h08;
  localparam S_FLO  = 6'h10;
  localparam S_FEND = 6'h20;
  localparam [47:0] SC_OFF = {`RIC_A_PDSC, `RIC_A_PBSC, `RIC_A_PASC};
  localparam [47:0] PS_OFF = {`RIC_A_PDPS, `RIC_A_PBPS, `RIC_A_PAPS};
  localparam [47:0] ES_OFF = {`RIC_A_PDES, `RIC_A_PBES, `RIC_A_PAES};

  reg  [5:0]  state;
  reg  [2:0]  cnt;
  reg  [31:0] shift;
  reg  [15:0] vaddr;
  reg  [7:0]  vhi;
  reg         nrst_q;
  reg  [7:0]  reset_cause_register;
  reg         irq_s1;
  reg         irq_s2;
  reg         irq_prev;
  reg         irq_pin_flag;
  reg         irq_pin_int_enable;
  reg         irq_detect_mode;
  reg         irq_pull_disable;
  reg         irq_pol;
  reg         irq_en;
  reg         low_voltage_warning_flag;
  reg         low_voltage_warning_int_enable;
  reg         lvw_prev;
  reg  [23:0] p_sel;
  reg  [23:0] p_es;
  reg  [2:0]  p_ie;
  reg  [2:0]  p_mod;
  reg  [3:0]  evt_stat;
  reg  [3:0]  evt_en;
  reg  [7:0]  rd_mux;
  reg  [31:0] pend;
  wire [2:0]  p_flag;
  wire [2:0]  p_ack;
  wire        wr_go = avs_write & ~avs_waitrequest;
  wire [7:0]  wd = avs_writedata[7:0];
  wire        wr_irq = wr_go & (avs_address == `RIC_A_IRQSC);
  wire        wr_lv = wr_go & (avs_address == `RIC_A_LVSC);
  wire        irq_asserted = irq_en & (irq_s2 ~^ irq_pol);
  wire        irq_ack = wr_irq & wd[`RIC_IRQ_ACK];
  wire        lvw_ack = wr_lv & wd[`RIC_LV_WACK];
  wire        lvw_rise = lv_warning & ~lvw_prev;
  wire        port_req = |(p_flag & p_ie);
  wire [3:0]  evt_in;
  wire [4:0]  pick;
  wire        take;
  wire [23:0] p_pins = {port_d_pins, port_b_pins, port_a_pins};
  integer     i;
  integer     j;

  // Lowest set vector number wins; slot 0 is reset, never requested
  function [4:0] ric_pick;
    input [31:0] p;
    integer k;
    begin
      ric_pick = 5'h00;
      for (k = 31; k >= 1; k = k - 1) begin
        if (p[k])
          ric_pick = k[4:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Port detectors
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_port
      assign p_ack[g] = wr_go & (avs_address == SC_OFF[16*g +: 16]) &
                        wd[`RIC_P_ACK];
      ric_port #(.W(8)) u_port (
        .clk      (clk),
        .nrst     (nrst),
        .pins     (p_pins[8*g +: 8]),
        .pin_sel  (p_sel[8*g +: 8]),
        .edge_sel (p_es[8*g +: 8]),
        .mode     (p_mod[g]),
        .ack      (p_ack[g]),
        .flag     (p_flag[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pending requests and vector choice
  always @* begin
    pend = ext_req & ~`RIC_V_RSVD;
    pend[0] = 1'b0;
    pend[`RIC_V_IRQ] = irq_pin_flag & irq_pin_int_enable;
    pend[`RIC_V_LVW] = low_voltage_warning_flag &
                       low_voltage_warning_int_enable;
    pend[`RIC_V_PORT] = port_req;
    // Only the software interrupt passes a set mask
    if (i_mask)
      pend = pend & (32'h0000_0001 << `RIC_V_SWI);
  end

  assign pick = ric_pick(pend);
  assign take = (state == S_IDLE) & core_boundary & (|pend);
  assign evt_in = {take, lvw_rise,
                   |(p_flag & ~p_ack),
                   irq_asserted & ~irq_prev};

  ////////////////////////////////////////////////////////////////////////
  // Reset and vector sequencer
  always @(posedge clk) begin
    if (!nrst) begin
      state        <= S_BOOT;
      cnt          <= 3'h0;
      shift        <= 32'h0000_0000;
      vaddr        <= `RIC_VEC_RST;
      vhi          <= 8'h00;
      mem_rd       <= 1'b0;
      mem_addr     <= `RIC_VEC_RST;
      stk_we       <= 1'b0;
      stk_addr     <= `RIC_SP_INIT;
      stk_data     <= 8'h00;
      pc_value     <= 16'h0000;
      pc_load      <= 1'b0;
      sp_value     <= `RIC_SP_INIT;
      sp_load      <= 1'b1;
      i_mask       <= 1'b1;
      reset_active <= 1'b1;
    end else begin
      pc_load <= 1'b0;
      sp_load <= 1'b0;
      if (core_sei)
        i_mask <= 1'b1;
      else if (core_cli)
        i_mask <= 1'b0;
      case (state)
        S_BOOT: begin
          mem_rd   <= 1'b1;
          mem_addr <= `RIC_VEC_RST;
          vaddr    <= `RIC_VEC_RST;
          state    <= S_FHI;
        end
        S_IDLE: begin
          if (take) begin
            vaddr    <= `RIC_VEC_RST - {10'h000, pick, 1'b0};
            stk_we   <= 1'b1;
            stk_addr <= core_sp;
            stk_data <= core_pc[7:0];
            shift    <= {core_ccr, core_a, core_x, core_pc[15:8]};
            cnt      <= `RIC_PUSH_N;
            state    <= S_PUSH;
          end
        end
        S_PUSH: begin
          if (cnt != 3'h1) begin
            stk_addr <= stk_addr - 16'h0001;
            stk_data <= shift[7:0];
            shift    <= {8'h00, shift[31:8]};
            cnt      <= cnt - 3'h1;
          end else begin
            stk_we   <= 1'b0;
            sp_value <= stk_addr - 16'h0001;
            sp_load  <= 1'b1;
            i_mask   <= 1'b1;
            mem_rd   <= 1'b1;
            mem_addr <= vaddr;
            state    <= S_FHI;
          end
        end
        S_FHI: begin
          mem_addr <= vaddr + 16'h0001;
          state    <= S_FLO;
        end
        S_FLO: begin
          vhi    <= mem_rdata;
          mem_rd <= 1'b0;
          state  <= S_FEND;
        end
        S_FEND: begin
          pc_value     <= {vhi, mem_rdata};
          pc_load      <= 1'b1;
          reset_active <= 1'b0;
          state        <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset cause capture; not cleared by reset so it survives it
  always @(posedge clk) begin
    nrst_q <= nrst;
    if (!nrst) begin
      // Unknown previous level at power-up also starts a fresh record
      if (!nrst_q)
        reset_cause_register <= reset_cause_register |
                                (rst_cause & ~`RIC_RST_HIDE);
      else
        reset_cause_register <= rst_cause & ~`RIC_RST_HIDE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags, control registers and Avalon slave
  always @(posedge clk) begin
    if (!nrst) begin
      avs_waitrequest                <= 1'b1;
      avs_readdata                   <= 32'h0000_0000;
      irq_s1                         <= 1'b0;
      irq_s2                         <= 1'b0;
      irq_prev                       <= 1'b0;
      irq_pin_flag                   <= 1'b0;
      irq_pin_int_enable             <= 1'b0;
      irq_detect_mode                <= 1'b0;
      irq_pull_disable               <= 1'b0;
      irq_pol                        <= 1'b0;
      irq_en                         <= 1'b0;
      irq_pull_up                    <= 1'b0;
      irq_pull_down                  <= 1'b0;
      irq_pin_level                  <= 1'b0;
      low_voltage_warning_flag       <= 1'b0;
      low_voltage_warning_int_enable <= 1'b0;
      lvw_prev                       <= 1'b0;
      lv_reset_en                    <= 1'b1;
      p_sel                          <= 24'h00_0000;
      p_es                           <= 24'h00_0000;
      p_ie                           <= 3'h0;
      p_mod                          <= 3'h0;
      evt_stat                       <= 4'h0;
      evt_en                         <= 4'h0;
      int_out                        <= 1'b0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= {24'h00_0000, rd_mux};
      irq_s1   <= irq_pin;
      irq_s2   <= irq_s1;
      irq_prev <= irq_asserted;
      lvw_prev <= lv_warning;
      // Detection beats a same-cycle acknowledge
      irq_pin_flag <= (irq_asserted & ~irq_prev) |
                      (irq_detect_mode & irq_asserted) |
                      (irq_pin_flag & ~irq_ack);
      low_voltage_warning_flag <= lvw_rise |
                                  (low_voltage_warning_flag & ~lvw_ack);
      irq_pin_level <= irq_en & irq_s2;
      irq_pull_up   <= irq_en & ~irq_pull_disable & ~irq_pol;
      irq_pull_down <= irq_en & ~irq_pull_disable & irq_pol;
      evt_stat <= evt_in | (evt_stat &
                  ~((wr_go & (avs_address == `RIC_A_EVCLR)) ?
                    wd[3:0] : 4'h0));
      int_out  <= |(evt_stat & evt_en);
      if (wr_irq) begin
        irq_pull_disable   <= wd[`RIC_IRQ_PDD];
        irq_pol            <= wd[`RIC_IRQ_POL];
        irq_en             <= wd[`RIC_IRQ_PE];
        irq_pin_int_enable <= wd[`RIC_IRQ_IE];
        irq_detect_mode    <= wd[`RIC_IRQ_MOD];
      end
      if (wr_lv) begin
        low_voltage_warning_int_enable <= wd[`RIC_LV_WIE];
        lv_reset_en                    <= wd[`RIC_LV_RE];
      end
      if (wr_go & (avs_address == `RIC_A_EVEN))
        evt_en <= wd[3:0];
      for (i = 0; i < 3; i = i + 1) begin
        if (wr_go & (avs_address == SC_OFF[16*i +: 16])) begin
          p_ie[i]  <= wd[`RIC_P_IE];
          p_mod[i] <= wd[`RIC_P_MOD];
        end
        if (wr_go & (avs_address == PS_OFF[16*i +: 16]))
          p_sel[8*i +: 8] <= wd;
        if (wr_go & (avs_address == ES_OFF[16*i +: 16]))
          p_es[8*i +: 8] <= wd;
      end
    end
  end

  // Acknowledge bits always read 0; unmapped reads 0
  always @* begin
    rd_mux = 8'h00;
    case (avs_address)
      `RIC_A_LVSC: rd_mux = {low_voltage_warning_flag, 1'b0,
                             low_voltage_warning_int_enable,
                             lv_reset_en, 4'h0};
      `RIC_A_IRQSC: rd_mux = {1'b0, irq_pull_disable, irq_pol, irq_en,
                              irq_pin_flag, 1'b0, irq_pin_int_enable,
                              irq_detect_mode};
      `RIC_A_RSTC: rd_mux = reset_cause_register;
      `RIC_A_EVST: rd_mux = {4'h0, evt_stat};
      `RIC_A_EVEN: rd_mux = {4'h0, evt_en};
      default: begin
        for (j = 0; j < 3; j = j + 1) begin
          if (avs_address == SC_OFF[16*j +: 16])
            rd_mux = {4'h0, p_flag[j], 1'b0, p_ie[j], p_mod[j]};
          if (avs_address == PS_OFF[16*j +: 16])
            rd_mux = p_sel[8*j +: 8];
          if (avs_address == ES_OFF[16*j +: 16])
            rd_mux = p_es[8*j +: 8];
        end
      end
    endcase
  end
endmodule // ric_top
`default_nettype wire

// ===== tb_reset_and_interrupt_control.sv
// Self-checking bench for ric_top: Avalon tasks, core stimulus.
// Assumes ric_mem_model answers the vector fetches.
`timescale 1ns/10ps
`default_nettype none
`include "ric_map.vh"
module tb_reset_and_interrupt_control;
  logic        clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [15:0] avs_address = 16'h0, core_pc = 16'h0, core_sp = 16'h0;
  logic [31:0] avs_writedata = 32'h0, ext_req = 32'h0, avs_readdata;
  logic        irq_pin = 1'b0, lv_warning = 1'b0, core_boundary = 1'b0;
  logic        core_sei = 1'b0, core_cli = 1'b0, avs_waitrequest;
  logic [7:0]  port_a_pins = 8'h0, port_b_pins = 8'h0, port_d_pins = 8'h0;
  logic [7:0]  rst_cause = 8'h0, core_x = 8'h0, core_a = 8'h0;
  logic [7:0]  core_ccr = 8'h0, mem_rdata, stk_data, rd;
  logic [15:0] mem_addr, stk_addr, pc_value, sp_value;
  logic        mem_rd, stk_we, pc_load, sp_load, i_mask, reset_active;
  logic        irq_pull_up, irq_pull_down, irq_pin_level, lv_reset_en;
  logic        int_out;
  integer      n_errors = 0, checks_done = 0, cyc = 0, seed = 32'hfbd1;
  integer      i, v, b;
  always #20 clk = ~clk;
  ric_top u_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq_pin,
    .port_a_pins, .port_b_pins, .port_d_pins, .lv_warning, .rst_cause,
    .ext_req, .core_boundary, .core_sei, .core_cli, .core_pc, .core_x,
    .core_a, .core_ccr, .core_sp, .mem_rdata, .mem_rd, .mem_addr, .stk_we,
    .stk_addr, .stk_data, .pc_value, .pc_load, .sp_value, .sp_load,
    .i_mask, .reset_active, .irq_pull_up, .irq_pull_down, .irq_pin_level,
    .lv_reset_en, .int_out);
  ric_mem_model u_mem (.clk, .mem_rd, .mem_addr, .mem_rdata);
  ////////////////////////////////////////////////////////////////////
  function [7:0] mb(input [15:0] a);
    mb = a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction
  function [15:0] ev(input integer n);
    ev = {mb(16'hfffe - 16'(2 * n)), mb(16'hffff - 16'(2 * n))};
  endfunction
  task results;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task bus(input w, input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge clk);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task till(input integer s);
    begin
      // No local limit; the cycle ceiling ends a hang
      while ((s == 0 ? pc_load : stk_we) !== 1'b1)
        @(posedge clk);
    end
  endtask
  task cli;
    begin
      @(posedge clk);
      core_cli <= 1'b1;
      @(posedge clk);
      core_cli <= 1'b0;
    end
  endtask
  task take(input integer n);
    logic [39:0] fr;
    integer j;
    begin
      fr = {8'($random(seed)), 32'($random(seed))};
      @(posedge clk);
      {core_ccr, core_a, core_x, core_pc} <= fr;
      core_boundary <= 1'b1;
      @(posedge clk);
      core_boundary <= 1'b0;
      till(1);
      for (j = 0; j < 5; j = j + 1) begin
        chk(stk_addr, core_sp - j);
        chk(stk_data, fr[8*j +: 8]);
        @(posedge clk);
      end
      till(0);
      chk(pc_value, ev(n));
      chk(i_mask, 1'b1);
    end
  endtask
  task do_reset;
    begin
      v = $random(seed);
      rst_cause <= v[7:0];
      nrst <= 1'b0;
      repeat (6) @(posedge clk);
      chk(sp_value, `RIC_SP_INIT);
      chk(i_mask, 1'b1);
      chk(reset_active, 1'b1);
      chk(lv_reset_en, 1'b1);
      nrst <= 1'b1;
      till(0);
      chk(pc_value, ev(0));
      core_sp <= 16'h0180 + v[15:8];
      bus(0, `RIC_A_RSTC, 8'h0);
      chk(rd, v[7:0] & 8'hfe);
      $display("reset test done");
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    do_reset;
    for (i = 0; i < 2; i = i + 1) begin
      b = $random(seed);
      bus(1, `RIC_A_PAPS + 16'(i), b[7:0]);
      bus(0, `RIC_A_PAPS + 16'(i), 8'h0);
      chk(rd, b[7:0]);
    end
    bus(0, 16'h1900, 8'h0);
    chk(avs_readdata, 32'h0);
    $display("register test done");
    // Software interrupt passes the mask, vector 5 must wait
    ext_req <= 32'h22;
    take(1);
    ext_req <= 32'h20;
    @(posedge clk);
    core_boundary <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      chk(stk_we, 1'b0);
    end
    core_boundary <= 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      v = 4 + ($random(seed) & 32'hff) % 15;
      b = 4 + ($random(seed) & 32'hff) % 28;
      if ((b > 18 && b < 23) || (b > 25 && b < 30))
        b = 31;
      cli;
      ext_req <= (32'h1 << v) | (32'h1 << b);
      take(v < b ? v : b);
      ext_req <= 32'h0;
    end
    $display("priority test done");
    bus(1, `RIC_A_IRQSC, 8'h33);
    irq_pin <= 1'b1;
    repeat (4) @(posedge clk);
    chk({irq_pull_up, irq_pull_down}, 2'b01);
    chk(irq_pin_level, 1'b1);
    bus(1, `RIC_A_IRQSC, 8'h37);
    bus(0, `RIC_A_IRQSC, 8'h0);
    chk(rd[3], 1'b1);
    irq_pin <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1, `RIC_A_IRQSC, 8'h76);
    bus(0, `RIC_A_IRQSC, 8'h0);
    chk(rd[3], 1'b0);
    chk({irq_pull_up, irq_pull_down}, 2'b00);
    irq_pin <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1, `RIC_A_IRQSC, 8'h76);
    bus(0, `RIC_A_IRQSC, 8'h0);
    chk(rd[3], 1'b0);
    irq_pin <= 1'b0;
    repeat (4) @(posedge clk);
    irq_pin <= 1'b1;
    repeat (4) @(posedge clk);
    cli;
    take(2);
    bus(1, `RIC_A_IRQSC, 8'h76);
    $display("irq pin test done");
    bus(1, `RIC_A_EVEN, 8'h01);
    repeat (3) @(posedge clk);
    chk(int_out, 1'b1);
    bus(1, `RIC_A_EVEN, 8'h00);
    repeat (3) @(posedge clk);
    chk(int_out, 1'b0);
    bus(1, `RIC_A_EVEN, 8'h01);
    bus(1, `RIC_A_EVCLR, 8'h0f);
    repeat (3) @(posedge clk);
    chk(int_out, 1'b0);
    bus(0, `RIC_A_EVST, 8'h0);
    chk(rd[0], 1'b0);
    $display("event test done");
    bus(1, `RIC_A_LVSC, 8'h20);
    lv_warning <= 1'b1;
    cli;
    take(3);
    lv_warning <= 1'b0;
    bus(1, `RIC_A_LVSC, 8'h60);
    bus(0, `RIC_A_LVSC, 8'h0);
    chk(rd, 8'h20);
    $display("low voltage test done");
    v = $random(seed);
    bus(1, `RIC_A_PDPS, 8'h1 << v[2:0]);
    bus(1, `RIC_A_PDES, 8'h1 << v[2:0]);
    bus(1, `RIC_A_PDSC, 8'h02);
    port_d_pins <= 8'h1 << v[2:0];
    repeat (4) @(posedge clk);
    bus(0, `RIC_A_PDSC, 8'h0);
    chk(rd[3], 1'b1);
    bus(1, `RIC_A_PDSC, 8'h06);
    bus(0, `RIC_A_PDSC, 8'h0);
    chk(rd[3], 1'b0);
    bus(1, `RIC_A_PDSC, 8'h07);
    repeat (4) @(posedge clk);
    bus(0, `RIC_A_PDSC, 8'h0);
    chk(rd[3], 1'b1);
    port_d_pins <= 8'h0;
    repeat (4) @(posedge clk);
    bus(1, `RIC_A_PDSC, 8'h0e);
    bus(0, `RIC_A_PDSC, 8'h0);
    chk(rd[3], 1'b0);
    port_d_pins <= 8'h1 << v[2:0];
    repeat (4) @(posedge clk);
    cli;
    take(22);
    $display("port test done");
    do_reset;
    bus(0, `RIC_A_PDSC, 8'h0);
    chk(rd, 8'h00);
    results;
  end
endmodule // tb_reset_and_interrupt_control
bind ric_top ric_props u_props (.clk, .nrst, .avs_address, .avs_read,
  .avs_readdata, .avs_waitrequest, .mem_rd, .mem_addr, .stk_we, .stk_addr,
  .sp_value, .sp_load, .i_mask, .reset_active, .irq_pull_up,
  .irq_pull_down, .pc_load, .int_out);
`default_nettype wire
